/* eprom_host_pkg.sv */
// Constants, command codes and state types for the EPROM host controller.
// Assumes a 100 MHz ref_clk; all pin timing is derived from that period.
package eprom_host_pkg;

   // ==========================================================================
   // Widths
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 8;
   localparam int TMR_W  = 23;

   // ==========================================================================
   // Timing in printed units
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_ACC_ADDR_NS = 450;    // Slow grade, so the fast grade is covered too.
   localparam int T_SETUP_NS    = 2000;   // Address, data and supply settle before a pulse.
   localparam int T_HOLD_NS     = 2000;   // Address and data held after a pulse.
   localparam int SYNC_STAGES   = 2;
   localparam int NS_PER_MS     = 1000000;
   localparam int PULSE_FAST_MS = 10;
   localparam int PULSE_STD_MS  = 50;
   localparam int PULSE_MAX_MS  = 55;

   // ==========================================================================
   // Derived cycle counts
   localparam logic [CNT_W-1:0] ACC_CYC   =
      CNT_W'((T_ACC_ADDR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
   localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] HOLD_CYC  = CNT_W'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] PULSE_FAST_CYC_DEF = TMR_W'(PULSE_FAST_MS * (NS_PER_MS / CLK_PERIOD_NS));
   localparam logic [TMR_W-1:0] PULSE_STD_CYC_DEF  = TMR_W'(PULSE_STD_MS * (NS_PER_MS / CLK_PERIOD_NS));
   localparam logic [TMR_W-1:0] PULSE_MAX_CYC_DEF  = TMR_W'(PULSE_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS));

   // ==========================================================================
   // Commands
   typedef enum logic [1:0] {
      OP_READ    = 2'h0,
      OP_PROGRAM = 2'h1,
      OP_VERIFY  = 2'h2
   } op_t;

   // ==========================================================================
   // Controller states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_SETUP  = 6'h02,
      ST_PULSE  = 6'h04,
      ST_HOLD   = 6'h08,
      ST_TURN   = 6'h10,
      ST_ACCESS = 6'h20
   } state_t;

   typedef struct packed {
      state_t              st;
      logic [DATA_W-1:0]   syncA;
      logic [DATA_W-1:0]   syncB;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   dataOut;
      logic                dataOe;
      logic                chipSelN;
      logic                pgm;
      logic                vpp;
      logic                verify;
      logic                longSel;
      logic [CNT_W-1:0]    cnt;
      logic                rspValid;
      logic [DATA_W-1:0]   rspData;
      logic                rspMismatch;
   } ctrl_state_t;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic             busy;
   } tmr_state_t;

endpackage

/* pulse_timer_if.sv */
// Handshake between the controller and its program pulse timer.
// Both ends run on ref_clk.
`timescale 1ns/1ns
`default_nettype none
interface pulse_timer_if;
   logic start;   // One-cycle request to begin timing a pulse.
   logic longSel; // High selects the standard pulse length.
   logic done;    // High in the last cycle of the pulse.

   modport ctrl  (output start, output longSel, input done);
   modport timer (input start, input longSel, output done);
endinterface
`default_nettype wire

/* pulse_timer.sv */
// Counts the width of one program pulse in ref_clk cycles.
// Assumes start is only raised while the timer is idle.
`timescale 1ns/1ns
`default_nettype none
module pulse_timer #(
   parameter logic [eprom_host_pkg::TMR_W-1:0] FAST_CYC = eprom_host_pkg::PULSE_FAST_CYC_DEF,
   parameter logic [eprom_host_pkg::TMR_W-1:0] STD_CYC  = eprom_host_pkg::PULSE_STD_CYC_DEF
) (
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   input  wire logic       clkEn,
   pulse_timer_if.timer    tmr
);
   eprom_host_pkg::tmr_state_t stateReg;
   eprom_host_pkg::tmr_state_t stateNext;

   // ==========================================================================
   // Load the length minus one, count down, flag the final cycle.
   always_comb begin
      stateNext = stateReg;
      if (tmr.start && !stateReg.busy) begin
         stateNext.busy = 1'b1;
         stateNext.cnt  = (tmr.longSel ? STD_CYC : FAST_CYC) - 1'b1;
      end else if (stateReg.busy) begin
         if (stateReg.cnt == '0) begin
            stateNext.busy = 1'b0;
         end else begin
            stateNext.cnt = stateReg.cnt - 1'b1;
         end
      end
   end

   assign tmr.done = stateReg.busy && (stateReg.cnt == '0);

   // ==========================================================================
   // State register, frozen while the clock enable is low.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stateReg <= '0;
      end else if (clkEn) begin
         stateReg <= stateNext;
      end
   end

   // ==========================================================================
   // Checks.
   a_timer_ends: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (tmr.done && clkEn) |=> !stateReg.busy)
      else $error("Pulse timer did not stop after its final cycle.");
endmodule // pulse_timer
`default_nettype wire

/* eprom_host_ctrl.sv */
// Host controller that reads, programs and verifies a 2048 x 8 UV EPROM over its pins.
// Assumes the board switches the program supply from vppHigh and resolves the data bus.
// What this block does
// - Read: drive chip select low and the program pin low, then sample data.
// - Chip select high frees the data lines; host drives them only then.
// - Host raises the program pin while idle to power the device down.
// - Programming needs the high supply and chip select high.
// - Each location gets one 10 ms pulse; 50 ms also accepted.
// - Locations may be programmed in any order.
// - Drive data, hold address and data stable, then pulse the program pin.
// - The program pulse never exceeds 55 ms.
// - Inhibited device: program pin low, chip select high, pulse ignored.
// - Verify with the high supply kept on; device outputs the stored byte.
`timescale 1ns/1ns
`default_nettype none
module eprom_host_ctrl #(
   parameter logic [eprom_host_pkg::TMR_W-1:0] PULSE_FAST_CYC = eprom_host_pkg::PULSE_FAST_CYC_DEF,
   parameter logic [eprom_host_pkg::TMR_W-1:0] PULSE_STD_CYC  = eprom_host_pkg::PULSE_STD_CYC_DEF,
   parameter logic [eprom_host_pkg::TMR_W-1:0] PULSE_MAX_CYC  = eprom_host_pkg::PULSE_MAX_CYC_DEF
) (
   input  wire logic                              ref_clk,
   input  wire logic                              sys_rst,
   input  wire logic                              clkEn,
   input  wire logic                              cmdValid,
   output logic                                   cmdReady,
   input  wire logic [1:0]                        cmdOp,
   input  wire logic [eprom_host_pkg::ADDR_W-1:0] cmdAddr,
   input  wire logic [eprom_host_pkg::DATA_W-1:0] cmdData,
   input  wire logic                              cmdPulseLong,
   output logic                                   rspValid,
   output logic [eprom_host_pkg::DATA_W-1:0]      rspData,
   output logic                                   rspMismatch,
   output logic [eprom_host_pkg::ADDR_W-1:0]      romAddr,
   output logic                                   chipSelectN,
   output logic                                   powerdownProgramPin,
   output logic                                   vppHigh,
   input  wire logic [eprom_host_pkg::DATA_W-1:0] romDataIn,
   output logic [eprom_host_pkg::DATA_W-1:0]      romDataOut,
   output logic                                   romDataOe
);
   eprom_host_pkg::ctrl_state_t stateReg;
   eprom_host_pkg::ctrl_state_t stateNext;
   pulse_timer_if               tmrBus ();

   // ==========================================================================
   // Pulse timer.
   pulse_timer #(
      .FAST_CYC (PULSE_FAST_CYC),
      .STD_CYC  (PULSE_STD_CYC)
   ) pulse_timer_inst (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .clkEn    (clkEn),
      .tmr      (tmrBus.timer)
   );

   // ==========================================================================
   // Command handshake and the pulse request.
   assign cmdReady       = (stateReg.st == eprom_host_pkg::ST_IDLE);
   assign tmrBus.longSel = stateReg.longSel;
   assign tmrBus.start   = (stateReg.st == eprom_host_pkg::ST_SETUP) && (stateReg.cnt == '0);

   // ==========================================================================
   // Sequencer.
   always_comb begin
      stateNext          = stateReg;
      stateNext.syncA    = romDataIn;
      stateNext.syncB    = stateReg.syncA;
      stateNext.rspValid = 1'b0;
      case (stateReg.st)
         eprom_host_pkg::ST_IDLE: begin
            // Parked powered down with outputs released.
            stateNext.chipSelN = 1'b1;
            stateNext.pgm      = 1'b1;
            stateNext.vpp      = 1'b0;
            stateNext.dataOe   = 1'b0;
            if (cmdValid) begin
               // Any address is accepted in any order.
               stateNext.addr    = cmdAddr;
               stateNext.dataOut = cmdData;
               stateNext.longSel = cmdPulseLong;
               case (cmdOp)
                  eprom_host_pkg::OP_PROGRAM: begin
                     stateNext.vpp      = 1'b1;
                     stateNext.chipSelN = 1'b1;
                     stateNext.pgm      = 1'b0;
                     stateNext.dataOe   = 1'b1;
                     stateNext.verify   = 1'b1;
                     stateNext.cnt      = eprom_host_pkg::SETUP_CYC;
                     stateNext.st       = eprom_host_pkg::ST_SETUP;
                  end
                  eprom_host_pkg::OP_VERIFY: begin
                     stateNext.vpp      = 1'b1;
                     stateNext.chipSelN = 1'b0;
                     stateNext.pgm      = 1'b0;
                     stateNext.verify   = 1'b1;
                     stateNext.cnt      = eprom_host_pkg::ACC_CYC;
                     stateNext.st       = eprom_host_pkg::ST_ACCESS;
                  end
                  default: begin
                     stateNext.chipSelN = 1'b0;
                     stateNext.pgm      = 1'b0;
                     stateNext.verify   = 1'b0;
                     stateNext.cnt      = eprom_host_pkg::ACC_CYC;
                     stateNext.st       = eprom_host_pkg::ST_ACCESS;
                  end
               endcase
            end
         end
         eprom_host_pkg::ST_SETUP: begin
            // Address, data and high supply settle before the pulse.
            if (stateReg.cnt == '0) begin
               stateNext.pgm = 1'b1;
               stateNext.st  = eprom_host_pkg::ST_PULSE;
            end else begin
               stateNext.cnt = stateReg.cnt - 1'b1;
            end
         end
         eprom_host_pkg::ST_PULSE: begin
            if (tmrBus.done) begin
               stateNext.pgm = 1'b0;
               stateNext.cnt = eprom_host_pkg::HOLD_CYC;
               stateNext.st  = eprom_host_pkg::ST_HOLD;
            end
         end
         eprom_host_pkg::ST_HOLD: begin
            // Data stays driven after the pulse, then the bus is released.
            if (stateReg.cnt == '0) begin
               stateNext.dataOe = 1'b0;
               stateNext.st     = eprom_host_pkg::ST_TURN;
            end else begin
               stateNext.cnt = stateReg.cnt - 1'b1;
            end
         end
         eprom_host_pkg::ST_TURN: begin
            // One released cycle before the device may drive; supply stays high.
            stateNext.chipSelN = 1'b0;
            stateNext.cnt      = eprom_host_pkg::ACC_CYC;
            stateNext.st       = eprom_host_pkg::ST_ACCESS;
         end
         eprom_host_pkg::ST_ACCESS: begin
            if (stateReg.cnt == '0) begin
               // Sample after the access time; verify compares with the intended byte.
               stateNext.rspValid    = 1'b1;
               stateNext.rspData     = stateReg.syncB;
               stateNext.rspMismatch = stateReg.verify && (stateReg.syncB != stateReg.dataOut);
               stateNext.chipSelN    = 1'b1;
               stateNext.pgm         = 1'b1;
               stateNext.vpp         = 1'b0;
               stateNext.st          = eprom_host_pkg::ST_IDLE;
            end else begin
               stateNext.cnt = stateReg.cnt - 1'b1;
            end
         end
         default: begin
            stateNext.st = eprom_host_pkg::ST_IDLE;
         end
      endcase
   end

   // ==========================================================================
   // State register, frozen while the clock enable is low.
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stateReg          <= '0;
         stateReg.st       <= eprom_host_pkg::ST_IDLE;
         stateReg.chipSelN <= 1'b1;
         stateReg.pgm      <= 1'b1;
      end else if (clkEn) begin
         stateReg <= stateNext;
      end
   end

   // ==========================================================================
   // Outputs straight from the state register.
   assign romAddr             = stateReg.addr;
   assign chipSelectN         = stateReg.chipSelN;
   assign powerdownProgramPin = stateReg.pgm;
   assign vppHigh             = stateReg.vpp;
   assign romDataOut          = stateReg.dataOut;
   assign romDataOe           = stateReg.dataOe;
   assign rspValid            = stateReg.rspValid;
   assign rspData             = stateReg.rspData;
   assign rspMismatch         = stateReg.rspMismatch;

   // ==========================================================================
   // Helper: length of the current program pulse in enabled cycles.
   logic [eprom_host_pkg::TMR_W-1:0] pulseLen;
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pulseLen <= '0;
      end else if (clkEn) begin
         pulseLen <= (powerdownProgramPin && vppHigh) ? pulseLen + 1'b1 : '0;
      end
   end

   // ==========================================================================
   // Checks.
   a_read_pins: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (stateReg.st == eprom_host_pkg::ST_ACCESS && !vppHigh) |-> (!chipSelectN && !powerdownProgramPin))
      else $error("Read access without select and program pin low.");
   a_no_contention: assert property (@(posedge ref_clk) disable iff (sys_rst)
      romDataOe |-> chipSelectN)
      else $error("Host drives data while chip select is low.");
   a_idle_powerdown: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cmdReady |-> (powerdownProgramPin && chipSelectN && !vppHigh && !romDataOe))
      else $error("Idle controller not parked in power down.");
   a_prog_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (vppHigh && $rose(powerdownProgramPin)) |-> (chipSelectN && romDataOe && $past(vppHigh)))
      else $error("Program pulse without high supply, select high and data.");
   a_pulse_width: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (vppHigh && $past(vppHigh) && $fell(powerdownProgramPin)) |->
      (pulseLen == (stateReg.longSel ? PULSE_STD_CYC : PULSE_FAST_CYC)))
      else $error("Program pulse width differs from the selected length.");
   a_pulse_max: assert property (@(posedge ref_clk) disable iff (sys_rst)
      pulseLen <= PULSE_MAX_CYC)
      else $error("Program pulse longer than the maximum.");
   a_prog_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (powerdownProgramPin && vppHigh) |=> ($stable(romAddr) && $stable(romDataOut) && romDataOe))
      else $error("Address or data moved during the program pulse.");
   a_verify_supply: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (stateReg.st == eprom_host_pkg::ST_TURN && clkEn) |=> (vppHigh && !chipSelectN && !powerdownProgramPin))
      else $error("Verify after programming dropped the high supply.");
   a_access_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (!chipSelectN && $past(!chipSelectN)) |-> $stable(romAddr))
      else $error("Address changed during an access.");
   a_read_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (cmdValid && cmdReady && clkEn && cmdOp == eprom_host_pkg::OP_READ) |-> ##[1:60] rspValid)
      else $error("Read answer late.");

   c_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
      rspValid && !stateReg.verify);
   c_program: cover property (@(posedge ref_clk) disable iff (sys_rst)
      vppHigh && $past(vppHigh) && $fell(powerdownProgramPin));
   c_mismatch: cover property (@(posedge ref_clk) disable iff (sys_rst)
      rspValid && rspMismatch);
endmodule // eprom_host_ctrl
`default_nettype wire

/* eprom_device_model.sv */
// Behavioural model of the 2048 x 8 UV EPROM that the host controller drives.
// Assumes the bench resolves the shared data bus from the host enable.
`timescale 1ns/1ns
`default_nettype none
module eprom_device_model #(
   parameter int ACC_NS  = 450,
   parameter int MAXP_NS = 550
) (
   input  wire logic        chipSelectN,
   input  wire logic        powerdownProgramPin,
   input  wire logic        vppHigh,
   input  wire logic [10:0] romAddr,
   input  wire logic [7:0]  hostData,
   input  wire logic        hostOe,
   output var  logic [7:0]  devData,
   output var  logic        devOe,
   output var  logic [7:0]  errCount
);
   // ==========
   // Storage and polled pin state
   logic [7:0]  mem [0:2047];
   logic [12:0] prevCtl;
   logic        prevProg;
   logic        prog;
   logic [18:0] pinned;
   realtime     tChange;
   realtime     tStart;

   // The erased array reads as all ones.
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      {devData, devOe, errCount, prevCtl, prevProg, prog, pinned} = '0;
      tChange = 0;
      tStart = 0;
   end

   // Pins are polled between clock edges; the part itself needs no clock.
   always #2 begin
      if ({romAddr, chipSelectN, powerdownProgramPin} !== prevCtl) tChange = $realtime;
      prevCtl = {romAddr, chipSelectN, powerdownProgramPin};
      prog = vppHigh && chipSelectN && powerdownProgramPin;
      devOe = !chipSelectN && !powerdownProgramPin;
      if (devOe && $realtime - tChange >= ACC_NS) devData = mem[romAddr];
      else devData = ~devData; // Released or unsettled lines keep changing.
      if (prog && !prevProg) begin
         tStart = $realtime;
         pinned = {romAddr, hostData};
         if (!hostOe) errCount++;
      end
      if (!prog && prevProg) begin
         if ($realtime - tStart > MAXP_NS || pinned !== {romAddr, hostData}) errCount++;
         mem[pinned[18:8]] = mem[pinned[18:8]] & pinned[7:0];
      end
      prevProg = prog;
   end
endmodule // eprom_device_model
`default_nettype wire

/* uv_eprom_mode_control_bench.sv */
// Self-checking bench for the EPROM host controller against a device model.
// Assumes the package, timer interface, timer, controller and model compile first.
`timescale 1ns/1ns
`default_nettype none
module uv_eprom_mode_control_bench;
   // ==========
   // Parameters and signals
   localparam logic [22:0] FAST = 23'h000014;
   localparam logic [22:0] SLOW = 23'h000032;
   localparam logic [1:0]  RD   = eprom_host_pkg::OP_READ;
   localparam logic [1:0]  PG   = eprom_host_pkg::OP_PROGRAM;
   localparam logic [1:0]  VF   = eprom_host_pkg::OP_VERIFY;
   // Edges from the accept edge to the edge that raises the answer.
   localparam int          RLAT = int'(eprom_host_pkg::ACC_CYC) + 1;
   localparam int          PLAT = int'(eprom_host_pkg::SETUP_CYC) + int'(eprom_host_pkg::HOLD_CYC) + RLAT + 3;
   logic        ref_clk, sys_rst, clkEn, cmdValid, cmdReady, cmdPulseLong;
   logic        rspValid, rspMismatch, chipSelectN, powerdownProgramPin;
   logic        vppHigh, romDataOe, devOe;
   logic [1:0]  cmdOp;
   logic [10:0] cmdAddr, romAddr;
   logic [7:0]  cmdData, rspData, romDataIn, romDataOut, devData, errCount;
   int          num_errors, n_compared, pulseCnt, lastPulse, contention, freezeLen;

   // Free-running 100 MHz clock.
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   // ==========
   // Controller, device model and the shared data bus
   eprom_host_ctrl #(.PULSE_FAST_CYC(FAST), .PULSE_STD_CYC(SLOW), .PULSE_MAX_CYC(23'h000037))
   eprom_host_ctrl_inst (.ref_clk, .sys_rst, .clkEn, .cmdValid, .cmdReady, .cmdOp, .cmdAddr,
      .cmdData, .cmdPulseLong, .rspValid, .rspData, .rspMismatch, .romAddr, .chipSelectN,
      .powerdownProgramPin, .vppHigh, .romDataIn, .romDataOut, .romDataOe);
   eprom_device_model #(.ACC_NS(450), .MAXP_NS(550)) eprom_device_model_inst (.chipSelectN,
      .powerdownProgramPin, .vppHigh, .romAddr, .hostData(romDataOut), .hostOe(romDataOe),
      .devData, .devOe, .errCount);
   assign romDataIn = romDataOe ? romDataOut : devData;

   // Measures program pulse width in clocks and watches for two drivers on the bus, between edges.
   always @(negedge ref_clk) begin
      if (vppHigh && chipSelectN && powerdownProgramPin) pulseCnt++;
      else if (pulseCnt != 0) begin
         lastPulse = pulseCnt;
         pulseCnt = 0;
      end
      if (romDataOe === 1'b1 && (chipSelectN !== 1'b1 || devOe)) contention++;
   end

   // ==========
   // Shared tasks
   task automatic check(input string what, input logic [22:0] exp, input logic [22:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Issues one command, waits for its answer and judges latency, byte and flag.
   task automatic run_cmd(input logic [1:0] op, input logic [10:0] addr, input logic [7:0] data,
      input logic long, input int lat, input logic [7:0] expData, input logic expMis);
      int k;
      @(posedge ref_clk);
      cmdOp <= op;
      cmdAddr <= addr;
      cmdData <= data;
      cmdPulseLong <= long;
      cmdValid <= 1'b1;
      k = 0;
      // Ready is looked at between edges, so the next rising edge is the accept edge.
      @(negedge ref_clk);
      while (cmdReady !== 1'b1 && k < 100) begin
         @(negedge ref_clk);
         k++;
      end
      @(posedge ref_clk);
      cmdValid <= 1'b0;
      k = 0;
      // Count edges after the accept edge; the answer is read while it stands.
      do begin
         @(posedge ref_clk);
         k++;
         if (freezeLen > 0 && k == 10) clkEn <= 1'b0;
         if (freezeLen > 0 && k == 10 + freezeLen) clkEn <= 1'b1;
         @(negedge ref_clk);
      end while (rspValid !== 1'b1 && k < 2000);
      check("latency", lat, k);
      check("byte", expData, rspData);
      check("mismatch flag", expMis, rspMismatch);
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ==========
   // Scenarios
   task automatic test_idle();
      @(negedge ref_clk);
      check("select idle", 1'b1, chipSelectN);
      check("pin idle", 1'b1, powerdownProgramPin);
      check("supply idle", 1'b0, vppHigh);
      check("host drive idle", 1'b0, romDataOe);
      check("ready idle", 1'b1, cmdReady);
      $display("test_idle done");
   endtask

   task automatic test_fast_program();
      run_cmd(RD, 11'h123, 8'h00, 1'b0, RLAT, 8'hff, 1'b0);
      run_cmd(PG, 11'h7ff, 8'ha5, 1'b0, PLAT + 20, 8'ha5, 1'b0);
      check("fast pulse", FAST, lastPulse);
      run_cmd(RD, 11'h7ff, 8'h00, 1'b0, RLAT, 8'ha5, 1'b0);
      $display("test_fast_program done");
   endtask

   task automatic test_long_program();
      run_cmd(PG, 11'h000, 8'h3c, 1'b1, PLAT + 50, 8'h3c, 1'b0);
      check("long pulse", SLOW, lastPulse);
      run_cmd(2'h3, 11'h000, 8'h00, 1'b0, RLAT, 8'h3c, 1'b0);
      run_cmd(RD, 11'h123, 8'h00, 1'b0, RLAT, 8'hff, 1'b0);
      $display("test_long_program done");
   endtask

   // A read whose access is frozen for eight cycles by the clock enable.
   task automatic test_freeze();
      freezeLen = 8;
      run_cmd(RD, 11'h7ff, 8'h00, 1'b0, RLAT + 8, 8'ha5, 1'b0);
      freezeLen = 0;
      $display("test_freeze done");
   endtask

   task automatic test_no_restore();
      run_cmd(PG, 11'h7ff, 8'hff, 1'b0, PLAT + 20, 8'ha5, 1'b1);
      run_cmd(VF, 11'h7ff, 8'ha5, 1'b0, RLAT, 8'ha5, 1'b0);
      run_cmd(VF, 11'h7ff, 8'h00, 1'b0, RLAT, 8'ha5, 1'b1);
      check("bus contention", 23'h0, contention);
      check("model faults", 23'h0, errCount);
      $display("test_no_restore done");
   endtask

   // Watchdog sized well beyond the roughly 1,800 cycles the tests need.
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      stop_test();
   end

   // Main sequence: reset for 12 cycles, then every scenario in turn.
   initial begin
      {sys_rst, clkEn, cmdValid, cmdPulseLong} = 4'hc;
      {cmdOp, cmdAddr, cmdData} = '0;
      {num_errors, n_compared, pulseCnt, lastPulse, contention, freezeLen} = '0;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      test_idle();
      test_fast_program();
      test_long_program();
      test_freeze();
      test_no_restore();
      stop_test();
   end
endmodule // uv_eprom_mode_control_bench
`default_nettype wire
